// File: rtl/startup_defs.svh
`ifndef STARTUP_DEFS_SVH
`define STARTUP_DEFS_SVH
// register byte offsets
`define OFS_CTRL        12'h000
`define OFS_LENGTH      12'h004
`define OFS_STATUS      12'h008
`define OFS_EVENTS      12'h00c
// control field positions
`define CTRL_GO_BIT     0
`define CTRL_MEMCLR_BIT 1
`define CTRL_MEMFULL_BIT 2
`define CTRL_MASTER_BIT 3
`define CTRL_EXPRESS_BIT 4
`define CTRL_MODE_LSB   5
`define CTRL_PULLUP_BIT 7
`define CTRL_RESTART_BIT 8
// tap fields: done, io, reset, 2 bits each (tap = stage index 0..3)
`define TAP_DONE_LSB    0
`define TAP_IO_LSB      2
`define TAP_RST_LSB     4
// reset values
`define CTRL_RST        32'h0000_0080
`define TAPS_RST        6'h39
`define LENGTH_RST      24'h00_0000
// timing
`define MASTER_WAIT_US  250
`define CLK_MHZ         10
`define MASTER_WAIT_CYC (`MASTER_WAIT_US * `CLK_MHZ)
`define DONE_TAIL_CYC   3
`endif

// File: rtl/startup_pkg.sv
package startup_pkg;
  typedef enum logic [1:0] {
    cfgclk_wait_on_done  = 2'h0,
    userclk_wait_on_done = 2'h1,
    cfgclk_free_run      = 2'h2,
    userclk_free_run     = 2'h3
  } start_mode_t;
  typedef enum logic [4:0] {
    st_clear = 5'h01,
    st_hold  = 5'h02,
    st_wait  = 5'h04,
    st_load  = 5'h08,
    st_start = 5'h10
  } phase_t;
endpackage

// File: rtl/config_startup_sequencer.sv
// Notes on behaviour
// - start-up begins when memory is full and clock count equals length count
// - first edge after start condition sets stage 0 of five-stage shifter
// - taps drive done release, user io enable, chip-wide reset release
// - each event tap selectable, so events order freely by one clock
// - default: user io goes active one clock after done rises
// - default: chip-wide reset released two clocks after done rises
// - readback and most scan blocked until three clocks after done
// - wait-on-done modes feed sampled done line into stage three
// - free-run modes advance without looking at the done line
// - later stages advance on config clock or on user start-up clock
// - on config clock, stages zero through three give the timing
// - on user clock, stage one synchronises, adding one cycle uncertainty
// - in user wait mode, external low on done stalls progress
// - express mode only allows the two wait-on-done variants
// - outside express, count clocks from the very first, stored length
// - on mismatch a master keeps clocking until 24-bit counter wraps
// - express mode ignores length; done follows full data quota
// - external low on init delays; mode captured on init release
// - master waits up to 250 us after init high before configuring
// - done is open-drain; internal pull-up on by default
// - init released only after configuration memory is cleared
// - during power-on to configuration done low, init active, io off
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "startup_defs.svh"
module config_startup_sequencer
#(
  parameter int unsigned MASTER_WAIT = `MASTER_WAIT_CYC
)(
  input  wire logic        pclk,          // config clock, 10 MHz
  input  wire logic        presetn,       // async reset, low
  input  wire logic        psel,          // apb select
  input  wire logic        penable,       // apb enable
  input  wire logic        pwrite,        // apb direction
  input  wire logic [11:0] paddr,         // apb byte address
  input  wire logic [31:0] pwdata,        // apb write data
  output logic      [31:0] prdata,        // apb read data
  output logic             pready,        // apb ready
  output logic             pslverr,       // apb error
  input  wire logic        cfg_tick,      // one config clock of data loaded
  input  wire logic        wake_user_clock, // user start-up clock, a level
  input  wire logic        done_in,       // wired-and done pin level
  output logic             done_out,      // drive done low
  output logic             done_oe,       // done driver enable
  output logic             done_pullup,   // internal pull-up enable
  input  wire logic        init_in,       // init pin level
  output logic             init_out,      // drive init low
  output logic             init_oe,       // init driver enable
  input  wire logic [1:0]  mode_pins,     // start-up mode pins
  output logic [1:0]       mode_captured, // mode caught at init release
  output logic             cfg_ready,     // may start configuration
  output logic             io_active,     // user io enabled
  output logic             chip_wide_reset, // global reset, high holds
  output logic             config_complete // readback/scan allowed
);
  import startup_pkg::*;

  logic [31:0] ctrl_reg;
  logic [23:0] length_reg;
  logic [5:0]  taps_reg;
  logic [23:0] count_reg;
  logic [4:0]  stage_reg;
  logic [1:0]  tail_reg;
  logic [31:0] wait_reg;
  logic [2:0]  done_sync_reg, init_sync_reg, userclk_wait_on_done_reg;
  phase_t      phase_reg;
  start_mode_t mode_sel;
  logic        apb_wr, apb_rd, done_lvl, init_lvl, uclk_lvl, uclk_edge_reg;
  logic        uses_user, waits_done, start_cond, adv;
  logic        done_evt, io_evt, rst_evt;

  assign apb_wr   = psel && penable && pwrite;
  assign apb_rd   = psel && penable && !pwrite;
  assign mode_sel = start_mode_t'(ctrl_reg[`CTRL_MODE_LSB +: 2]);
  assign uses_user  = mode_sel[0];
  // express allows only wait-on-done variants
  assign waits_done = !mode_sel[1] || ctrl_reg[`CTRL_EXPRESS_BIT];

  // three-stage samplers; decision once stages two and three agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      done_sync_reg <= 3'h0;
      init_sync_reg <= 3'h0;
      userclk_wait_on_done_reg <= 3'h0;
    end
    else
    begin
      done_sync_reg <= {done_sync_reg[1:0], done_in};
      init_sync_reg <= {init_sync_reg[1:0], init_in};
      userclk_wait_on_done_reg <= {userclk_wait_on_done_reg[1:0], wake_user_clock};
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      done_lvl      <= 1'b0;
      init_lvl      <= 1'b0;
      uclk_lvl      <= 1'b0;
      uclk_edge_reg <= 1'b0;
    end
    else
    begin
      if (done_sync_reg[2] == done_sync_reg[1])
        done_lvl <= done_sync_reg[2];
      if (init_sync_reg[2] == init_sync_reg[1])
        init_lvl <= init_sync_reg[2];
      if (userclk_wait_on_done_reg[2] == userclk_wait_on_done_reg[1])
        uclk_lvl <= userclk_wait_on_done_reg[2];
      uclk_edge_reg <= (userclk_wait_on_done_reg[2] == userclk_wait_on_done_reg[1]) && userclk_wait_on_done_reg[2] && !uclk_lvl;
    end
  end

  // apb registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg   <= `CTRL_RST;
      length_reg <= `LENGTH_RST;
      taps_reg   <= `TAPS_RST;
    end
    else if (apb_wr)
    begin
      unique case (paddr)
        `OFS_CTRL:   ctrl_reg   <= pwdata;
        `OFS_LENGTH: length_reg <= pwdata[23:0];
        `OFS_EVENTS: taps_reg   <= pwdata[5:0];
        default:     ;
      endcase
    end
    else
      ctrl_reg[`CTRL_RESTART_BIT] <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !(paddr == `OFS_CTRL || paddr == `OFS_LENGTH ||
                 paddr == `OFS_STATUS || paddr == `OFS_EVENTS);
      unique case (paddr)
        `OFS_CTRL:   prdata <= ctrl_reg;
        `OFS_LENGTH: prdata <= {8'h0, length_reg};
        `OFS_STATUS: prdata <= {8'h0, count_reg[15:0], 3'h0, stage_reg};
        `OFS_EVENTS: prdata <= {26'h0, taps_reg};
        default:     prdata <= 32'h0;
      endcase
    end
  end

  // phase control: clear, hold off, master wait, load, start-up
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase_reg     <= st_clear;
      wait_reg      <= 32'h0;
      mode_captured <= 2'h0;
    end
    else if (ctrl_reg[`CTRL_RESTART_BIT])
      phase_reg <= st_clear;
    else
    begin
      unique case (phase_reg)
        st_clear: if (ctrl_reg[`CTRL_MEMCLR_BIT]) phase_reg <= st_hold;
        st_hold:
          if (init_lvl)
          begin
            mode_captured <= mode_pins;
            wait_reg      <= 32'h0;
            phase_reg     <= ctrl_reg[`CTRL_MASTER_BIT] ? st_wait : st_load;
          end
        st_wait:
        begin
          wait_reg <= wait_reg + 32'h1;
          if (wait_reg >= MASTER_WAIT - 1) phase_reg <= st_load;
        end
        st_load: if (start_cond) phase_reg <= st_start;
        st_start: ;
      endcase
    end
  end

  // clock count from the very first config clock, wraps at 24 bits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_reg <= 24'h0;
    else if (phase_reg != st_load)
      count_reg <= 24'h0;
    else if (cfg_tick)
      count_reg <= count_reg + 24'h1;
  end

  assign start_cond = (phase_reg == st_load) && ctrl_reg[`CTRL_MEMFULL_BIT] &&
                      (ctrl_reg[`CTRL_EXPRESS_BIT] || count_reg == length_reg);
  assign adv = uses_user ? uclk_edge_reg : 1'b1;

  // five-stage start-up shifter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stage_reg <= 5'h0;
    // restart clears at once; the registered outputs take the cleared stage one clock later
    else if (ctrl_reg[`CTRL_RESTART_BIT] ||
             (phase_reg != st_start && phase_reg != st_load))
      stage_reg <= 5'h0;
    else
    begin
      stage_reg[0] <= stage_reg[0] | start_cond;
      // on user clock stage one bridges domains
      if (uses_user ? adv : 1'b1) stage_reg[1] <= stage_reg[0];
      if (adv) stage_reg[2] <= stage_reg[1];
      if (adv && (!waits_done || done_lvl) && (!uses_user || !waits_done || done_lvl))
        stage_reg[3] <= stage_reg[2] & (!waits_done | done_lvl);
      if (adv) stage_reg[4] <= stage_reg[3];
    end
  end

  assign done_evt = stage_reg[taps_reg[`TAP_DONE_LSB +: 2]];
  assign io_evt   = stage_reg[taps_reg[`TAP_IO_LSB +: 2]];
  assign rst_evt  = stage_reg[taps_reg[`TAP_RST_LSB +: 2]];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      done_out        <= 1'b0;
      done_oe         <= 1'b1;
      done_pullup     <= 1'b1;
      init_out        <= 1'b0;
      init_oe         <= 1'b1;
      cfg_ready       <= 1'b0;
      io_active       <= 1'b0;
      chip_wide_reset <= 1'b1;
    end
    else
    begin
      done_oe         <= !done_evt;
      done_pullup     <= ctrl_reg[`CTRL_PULLUP_BIT];
      init_oe         <= phase_reg == st_clear;
      cfg_ready       <= phase_reg == st_load;
      io_active       <= io_evt;
      chip_wide_reset <= !rst_evt;
    end
  end

  // three full clocks after done seen high
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tail_reg        <= 2'h0;
      config_complete <= 1'b0;
    end
    else if (!(done_evt && done_lvl))
    begin
      tail_reg        <= 2'h0;
      config_complete <= 1'b0;
    end
    else if (tail_reg != 2'(`DONE_TAIL_CYC - 1))
      tail_reg <= tail_reg + 2'h1;
    else
      config_complete <= 1'b1;
  end

  property p_io_after_done;
    @(posedge pclk) disable iff (!presetn)
      $rose(done_evt) && taps_reg == `TAPS_RST && !uses_user && !waits_done |=> ##0 $rose(io_evt);
  endproperty
  a_io_after_done: assert property (p_io_after_done) else $error("io not one clock after done");
  property p_rst_after_done;
    @(posedge pclk) disable iff (!presetn)
      $rose(done_evt) && taps_reg == `TAPS_RST && !uses_user && !waits_done |-> ##2 rst_evt;
  endproperty
  a_rst_after_done: assert property (p_rst_after_done) else $error("reset release late");
  property p_start;
    @(posedge pclk) disable iff (!presetn) start_cond && !stage_reg[0] |=> stage_reg[0];
  endproperty
  a_start: assert property (p_start) else $error("stage zero not set");
  property p_no_early;
    @(posedge pclk) disable iff (!presetn) $rose(stage_reg[0]) |-> $past(start_cond);
  endproperty
  a_no_early: assert property (p_no_early) else $error("start without condition");
  property p_complete;
    @(posedge pclk) disable iff (!presetn) $rose(config_complete) |-> $past(done_lvl, 3);
  endproperty
  a_complete: assert property (p_complete) else $error("complete too early");
  property p_stall;
    @(posedge pclk) disable iff (!presetn)
      waits_done && !done_lvl && !stage_reg[3] |=> !stage_reg[3];
  endproperty
  a_stall: assert property (p_stall) else $error("advanced while done low");
  property p_init_hold;
    @(posedge pclk) disable iff (!presetn) phase_reg == st_clear |=> init_oe;
  endproperty
  a_init_hold: assert property (p_init_hold) else $error("init released early");
  property p_io_off;
    @(posedge pclk) disable iff (!presetn) phase_reg != st_start |=> !io_active;
  endproperty
  a_io_off: assert property (p_io_off) else $error("io active during config");
  c_start: cover property (@(posedge pclk) disable iff (!presetn) $rose(stage_reg[0]));
  c_done:  cover property (@(posedge pclk) disable iff (!presetn) $rose(config_complete));
  // outputs stay in their config state until the start-up phase
  property p_done_held;
    @(posedge pclk) disable iff (!presetn)
      phase_reg != st_start |=> done_oe;
  endproperty
  a_done_held: assert property (p_done_held) else $error("done released early");
  property p_reset_held;
    @(posedge pclk) disable iff (!presetn)
      phase_reg != st_start |=> chip_wide_reset;
  endproperty
  a_reset_held: assert property (p_reset_held) else $error("reset released early");
  // on the user clock later stages move only on a user edge
  property p_user_gate;
    @(posedge pclk) disable iff (!presetn)
      uses_user && !adv && phase_reg == st_start && !ctrl_reg[`CTRL_RESTART_BIT]
        |=> $stable(stage_reg[4:1]);
  endproperty
  a_user_gate: assert property (p_user_gate) else $error("moved off user edge");
  property p_express_start;
    @(posedge pclk) disable iff (!presetn)
      phase_reg == st_load && ctrl_reg[`CTRL_EXPRESS_BIT] && ctrl_reg[`CTRL_MEMFULL_BIT] &&
      !ctrl_reg[`CTRL_RESTART_BIT] |=> stage_reg[0];
  endproperty
  a_express_start: assert property (p_express_start) else $error("no express start");
  property p_mode_capture;
    @(posedge pclk) disable iff (!presetn)
      phase_reg == st_hold && init_lvl && !ctrl_reg[`CTRL_RESTART_BIT]
        |=> mode_captured == $past(mode_pins);
  endproperty
  a_mode_capture: assert property (p_mode_capture) else $error("mode not captured");
  c_user:  cover property (@(posedge pclk) disable iff (!presetn) uses_user && $rose(io_active));
  c_stall: cover property (@(posedge pclk) disable iff (!presetn)
                           waits_done && stage_reg[2] && !done_lvl);
  c_restart: cover property (@(posedge pclk) disable iff (!presetn)
                             $rose(ctrl_reg[`CTRL_RESTART_BIT]));
endmodule

// File: verification/cfg_source_model.sv
`timescale 1ns/10ps
module cfg_source_model (
  input  wire logic        pclk,        // config clock
  input  wire logic        presetn,     // async reset, low
  input  wire logic        done_out,    // device done value
  input  wire logic        done_oe,     // device pulls done
  input  wire logic        done_pullup, // internal pull-up on
  input  wire logic        init_out,    // device init value
  input  wire logic        init_oe,     // device pulls init
  input  wire logic        hold_init,   // peer holds init low
  input  wire logic        hold_done,   // peer holds done low
  input  wire logic [23:0] tick_n,      // ticks to send
  input  wire logic        tick_go,     // load tick_n
  output logic             cfg_tick,    // one clock of data
  output logic             done_in,     // wired-and done
  output logic             init_in      // wired-and init
);
  logic [23:0] left_reg;
  // no board pull-up on done: without the internal one it reads low
  assign done_in  = done_pullup && !(done_oe && !done_out) && !hold_done;
  assign init_in  = !(init_oe && !init_out) && !hold_init;
  assign cfg_tick = (left_reg != 24'h0);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      left_reg <= 24'h0;
    else if (tick_go)
      left_reg <= tick_n;
    else if (left_reg != 24'h0)
      left_reg <= left_reg - 24'h1;
  end
endmodule

// File: verification/test_config_startup_sequencer.sv
`timescale 1ns/10ps
`include "startup_defs.svh"
`define CHK(nm, ex, got) \
  begin \
    samples_checked++; \
    if ((got) !== (ex)) \
    begin \
      $display("mismatch %s exp %0h got %0h", nm, ex, got); \
      n_fail++; \
    end \
  end
module test_config_startup_sequencer;
  import startup_pkg::*;
  localparam int MW  = 10;
  localparam int LEN = 20;
  typedef struct {logic [11:0] a; logic w; logic [31:0] d; logic [31:0] x; logic e;} row_t;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic        pready, pslverr, er, cfg_tick, wake_user_clock = 0, done_in, done_out, done_oe;
  logic        done_pullup, init_in, init_out, init_oe, cfg_ready, io_active;
  logic        chip_wide_reset, config_complete, hold_init = 1, hold_done = 0, tick_go = 0;
  logic [1:0]  mode_pins = 0, mode_captured;
  logic [23:0] tick_n = 0;
  int          n_fail, samples_checked, cyc, t_doe, t_din, t_io, t_rst, t_cc, t_ini, t_rdy;
  row_t rows[7] = '{'{`OFS_CTRL, 0, 0, `CTRL_RST, 0}, '{`OFS_EVENTS, 0, 0, 32'h39, 0},
    '{`OFS_LENGTH, 0, 0, 0, 0}, '{`OFS_LENGTH, 1, 32'hff12_3456, 0, 0},
    '{`OFS_LENGTH, 0, 0, 32'h0012_3456, 0}, '{12'h010, 1, 32'h1, 0, 1}, '{12'h010, 0, 0, 0, 1}};
  config_startup_sequencer #(.MASTER_WAIT(MW)) config_startup_sequencer_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cfg_tick(cfg_tick), .wake_user_clock(wake_user_clock), .done_in(done_in),
    .done_out(done_out), .done_oe(done_oe), .done_pullup(done_pullup), .init_in(init_in),
    .init_out(init_out), .init_oe(init_oe), .mode_pins(mode_pins),
    .mode_captured(mode_captured), .cfg_ready(cfg_ready), .io_active(io_active),
    .chip_wide_reset(chip_wide_reset), .config_complete(config_complete));
  cfg_source_model cfg_source_model_inst (
    .pclk(pclk), .presetn(presetn), .done_out(done_out), .done_oe(done_oe),
    .done_pullup(done_pullup), .init_out(init_out), .init_oe(init_oe),
    .hold_init(hold_init), .hold_done(hold_done), .tick_n(tick_n), .tick_go(tick_go),
    .cfg_tick(cfg_tick), .done_in(done_in), .init_in(init_in));
  always #50 pclk = !pclk;
  always
  begin
    repeat (2) @(posedge pclk);
    wake_user_clock <= !wake_user_clock;
  end
  // first-seen cycle of each event, cleared by run
  always @(posedge pclk)
  begin
    cyc++;
    if (t_doe < 0 && done_oe === 1'b0) t_doe = cyc;
    if (t_din < 0 && done_in === 1'b1) t_din = cyc;
    if (t_io < 0 && io_active === 1'b1) t_io = cyc;
    if (t_rst < 0 && chip_wide_reset === 1'b0) t_rst = cyc;
    if (t_cc < 0 && config_complete === 1'b1) t_cc = cyc;
    if (t_ini < 0 && init_in === 1'b1) t_ini = cyc;
    if (t_rdy < 0 && cfg_ready === 1'b1) t_rdy = cyc;
  end
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // only the watchdog ends a wait that never sees pready
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata; er = pslverr; psel <= 0; penable <= 0;
  endtask
  task automatic run(input logic [1:0] m, input logic [5:0] taps, input logic x,
                     input int extra, input int hold);
    logic [31:0] c;
    c = 32'h88 | ({30'h0, m} << 5) | ({31'h0, x} << 4);
    presetn <= 0; hold_init <= 1; mode_pins <= m;
    repeat (12) @(posedge pclk);
    presetn <= 1;
    {t_doe, t_din, t_io, t_rst, t_cc, t_ini, t_rdy} = {7{-32'sd1}};
    `CHK("rst_state", 5'b10101, {done_oe, io_active, chip_wide_reset, config_complete, done_pullup})
    apb(`OFS_EVENTS, 1, {26'h0, taps});
    apb(`OFS_LENGTH, 1, LEN);
    apb(`OFS_CTRL, 1, c | 32'h2);
    repeat (5) @(posedge pclk);
    `CHK("early_rdy", 1'b0, cfg_ready)
    hold_init <= 0;
    repeat (MW + 30) @(posedge pclk);
    `CHK("master_wait", 1, t_rdy - t_ini >= MW && t_rdy - t_ini <= MW + 8)
    `CHK("mode_cap", m, mode_captured)
    tick_n <= 24'(LEN + extra); tick_go <= 1;
    @(posedge pclk);
    tick_go <= 0;
    repeat (LEN + extra + 3) @(posedge pclk);
    `CHK("io_off", 1'b0, io_active)
    hold_done <= (hold > 0);
    apb(`OFS_CTRL, 1, c | 32'h4);
    repeat (hold) @(posedge pclk);
    hold_done <= 0;
    repeat (40) @(posedge pclk);
  endtask
  task automatic final_report;
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #(100 * 60000);
    n_fail++;
    final_report;
  end
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    foreach (rows[i])
    begin
      apb(rows[i].a, rows[i].w, rows[i].d);
      `CHK("apb_err", rows[i].e, er)
      if (!rows[i].w) `CHK("apb_rd", rows[i].x, rd)
    end
    // default lags hold where the sampled done level does not gate stage three
    run(cfgclk_free_run, 6'h39, 0, 0, 0);
    `CHK("done_seen", 1, t_doe > 0)
    `CHK("io_lag", 1, t_io - t_doe)
    `CHK("rst_lag", 2, t_rst - t_doe)
    `CHK("complete", 1, t_cc - t_din >= 3)
    run(cfgclk_free_run, 6'h27, 0, 0, 0);
    `CHK("io_early", -2, t_io - t_doe)
    `CHK("rst_early", -1, t_rst - t_doe)
    run(cfgclk_wait_on_done, 6'h39, 0, 1, 0);
    `CHK("stray_tick", -1, t_doe)
    run(cfgclk_wait_on_done, 6'h39, 0, 0, 10);
    `CHK("done_gate", 1, t_rst > t_din && t_din > t_doe)
    run(cfgclk_free_run, 6'h39, 0, 0, 10);
    `CHK("free_run", 2, t_rst - t_doe)
    run(userclk_wait_on_done, 6'h39, 0, 0, 10);
    `CHK("user_stall", 1, t_io > t_doe && t_rst > t_din)
    run(userclk_free_run, 6'h39, 0, 0, 0);
    `CHK("user_order", 1, t_io > t_doe && t_rst > t_io)
    run(cfgclk_free_run, 6'h39, 1, 5, 10);
    `CHK("express_done", 1, t_doe > 0)
    `CHK("express_sync", 1, t_rst > t_din)
    apb(`OFS_CTRL, 1, 32'h180);
    repeat (3) @(posedge pclk);
    `CHK("restart", 3'b101, {done_oe, io_active, chip_wide_reset})
    `CHK("restart_init", 2'b01, {config_complete, init_oe})
    final_report;
  end
endmodule
